/* File: dlic_map.vh */
/*
 * register map, field positions and reset values of the dual level interrupt controller.
 * assumes a 32-bit apb slave with one aligned word per register.
 */
`ifndef DLIC_MAP_VH
`define DLIC_MAP_VH

`define DLIC_W 32
`define DLIC_AW 6

// ****************
// register byte offsets
// ****************
`define DLIC_NRM_RAW 6'h00
`define DLIC_NRM_EN 6'h04
`define DLIC_NRM_CLR 6'h08
`define DLIC_NRM_STA 6'h0C
`define DLIC_FST_RAW 6'h10
`define DLIC_FST_EN 6'h14
`define DLIC_FST_CLR 6'h18
`define DLIC_FST_STA 6'h1C
`define DLIC_SWI_CFG 6'h20
`define DLIC_EVT_STA 6'h24
`define DLIC_EVT_MSK 6'h28

// ****************
// field positions and reset values
// ****************
`define DLIC_SUM_BIT 0
`define DLIC_SWI_BIT 1
`define DLIC_CFG_NRM_BIT 1
`define DLIC_CFG_FST_BIT 2
`define DLIC_EVT_NRM_BIT 0
`define DLIC_EVT_FST_BIT 1
`define DLIC_EVT_W 2
`define DLIC_ZERO 32'h00000000
`define DLIC_EVT_ZERO 2'h0
`define DLIC_CFG_RST 2'h0

`endif

/* File: dlic_top.v */
/*
 * dual level interrupt controller: 30 request lines (src_req bits 31:2), normal and fast request outputs,
 * apb register slave, sticky event status with mask and one level interrupt output.
 * assumes src_req is asynchronous to core_clk and that sources hold requests long enough.
 */
`timescale 1ns/1ps
`include "dlic_map.vh"

module dlic_top (
   // clock and reset
   input wire core_clk,
   input wire sys_rst,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // peripheral requests
   input wire [31:0] src_req,
   // requests to the core
   output reg normal_req,
   output reg fast_req,
   // event interrupt
   output reg evt_irq
);

   // ****************
   // request synchroniser
   // ****************
   reg [31:0] sync1_q;
   reg [31:0] sync2_q;
   always @(posedge core_clk) begin
      if (sys_rst) begin
         sync1_q <= `DLIC_ZERO;
         sync2_q <= `DLIC_ZERO;
      end else begin
         sync1_q <= src_req;
         sync2_q <= sync1_q;
      end
   end

   // ****************
   // state
   // ****************
   reg [31:0] nrm_en_q;
   reg [31:0] fst_en_q;
   reg [1:0] cfg_q;
   reg [1:0] evt_sta_q;
   reg [1:0] evt_msk_q;
   reg nrm_prev_q;
   reg fst_prev_q;

   // source bits usable in enable registers: not bit 0 nor the software bit
   function [31:0] en_bits;
      input [31:0] v;
      begin
         en_bits = v;
         en_bits[`DLIC_SUM_BIT] = 1'b0;
         en_bits[`DLIC_SWI_BIT] = 1'b0;
      end
   endfunction

   function sel;
      input [5:0] a;
      input [5:0] off;
      begin
         sel = (a == off);
      end
   endfunction

   // ****************
   // raw and masked status
   // ****************
   reg [31:0] nrm_raw;
   reg [31:0] fst_raw;
   reg [31:0] nrm_sta;
   reg [31:0] fst_sta;
   reg fst_or;
   always @* begin
      fst_raw = en_bits(sync2_q);
      fst_raw[`DLIC_SWI_BIT] = cfg_q[`DLIC_CFG_FST_BIT - 1];
      fst_sta = fst_raw & fst_en_q;
      fst_sta[`DLIC_SWI_BIT] = fst_raw[`DLIC_SWI_BIT];
      fst_or = |fst_sta[31:1];
      fst_raw[`DLIC_SUM_BIT] = fst_or;
      fst_sta[`DLIC_SUM_BIT] = fst_or;
      nrm_raw = en_bits(sync2_q);
      nrm_raw[`DLIC_SWI_BIT] = cfg_q[`DLIC_CFG_NRM_BIT - 1];
      nrm_sta = nrm_raw & nrm_en_q;
      nrm_sta[`DLIC_SWI_BIT] = nrm_raw[`DLIC_SWI_BIT];
      nrm_raw[`DLIC_SUM_BIT] = fst_or;
      nrm_sta[`DLIC_SUM_BIT] = fst_or;
   end

   // ****************
   // apb register access
   // ****************
   wire [5:0] a = paddr[5:0];
   wire hit = (paddr[31:6] == 26'h0000000) && (paddr[1:0] == 2'h0) &&
      (paddr[5:2] <= 4'hA);
   wire acc = psel && penable && !pready;
   wire wr = acc && pwrite && hit;
   wire rd = acc && !pwrite && hit;
   wire [31:0] wv = en_bits(pwdata);

   reg [31:0] rdat;
   always @* begin
      rdat = `DLIC_ZERO;
      if (sel(a, `DLIC_NRM_RAW)) rdat = nrm_raw;
      if (sel(a, `DLIC_NRM_EN)) rdat = nrm_en_q;
      if (sel(a, `DLIC_NRM_STA)) rdat = nrm_sta;
      if (sel(a, `DLIC_FST_RAW)) rdat = fst_raw;
      if (sel(a, `DLIC_FST_EN)) rdat = fst_en_q;
      if (sel(a, `DLIC_FST_STA)) rdat = fst_sta;
      if (sel(a, `DLIC_SWI_CFG)) rdat = {29'h00000000, cfg_q, 1'b0};
      if (sel(a, `DLIC_EVT_STA)) rdat = {30'h00000000, evt_sta_q};
      if (sel(a, `DLIC_EVT_MSK)) rdat = {30'h00000000, evt_msk_q};
   end

   // rising edges of the two core requests as events
   wire [1:0] evt_set = {fst_or & !fst_prev_q, (|nrm_sta) & !nrm_prev_q};

   always @(posedge core_clk) begin
      if (sys_rst) begin
         nrm_en_q <= `DLIC_ZERO;
         fst_en_q <= `DLIC_ZERO;
         cfg_q <= `DLIC_CFG_RST;
         evt_sta_q <= `DLIC_EVT_ZERO;
         evt_msk_q <= `DLIC_EVT_ZERO;
         nrm_prev_q <= 1'b0;
         fst_prev_q <= 1'b0;
         prdata <= `DLIC_ZERO;
         pready <= 1'b0;
         pslverr <= 1'b0;
         normal_req <= 1'b0;
         fast_req <= 1'b0;
         evt_irq <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
         pslverr <= acc && !hit;
         prdata <= rd ? rdat : `DLIC_ZERO;
         if (wr && sel(a, `DLIC_NRM_EN)) begin
            nrm_en_q <= nrm_en_q | wv;
            fst_en_q <= fst_en_q & ~wv;
         end
         if (wr && sel(a, `DLIC_FST_EN)) begin
            fst_en_q <= fst_en_q | wv;
            nrm_en_q <= nrm_en_q & ~wv;
         end
         if (wr && sel(a, `DLIC_NRM_CLR))
            nrm_en_q <= nrm_en_q & ~wv;
         if (wr && sel(a, `DLIC_FST_CLR))
            fst_en_q <= fst_en_q & ~wv;
         if (wr && sel(a, `DLIC_SWI_CFG))
            cfg_q <= pwdata[`DLIC_CFG_FST_BIT:`DLIC_CFG_NRM_BIT];
         if (wr && sel(a, `DLIC_EVT_MSK))
            evt_msk_q <= pwdata[`DLIC_EVT_W-1:0];
         // read clears, a new event in the same cycle wins
         if (rd && sel(a, `DLIC_EVT_STA))
            evt_sta_q <= evt_set;
         else
            evt_sta_q <= evt_sta_q | evt_set;
         nrm_prev_q <= |nrm_sta;
         fst_prev_q <= fst_or;
         normal_req <= |nrm_sta;
         fast_req <= fst_or;
         evt_irq <= |(evt_sta_q & evt_msk_q);
      end
   end

endmodule

/* File: dlic_core_model.sv */
/* core side model: samples the two request levels; needs core_clk */
`timescale 1ns/1ps
module dlic_core_model(input wire core_clk, input wire normal_req, input wire fast_req,
   output logic [1:0] taken);
   always @(posedge core_clk) taken <= {fast_req, normal_req};
endmodule

/* File: dlic_props.sv */
/* port assertions for dlic_top; bound to every instance */
`timescale 1ns/1ps
module dlic_props(input wire core_clk, input wire sys_rst, input wire psel,
   input wire penable, input wire pwrite, input wire [31:0] paddr, input wire [31:0] prdata,
   input wire pready, input wire pslverr, input wire [31:0] src_req,
   input wire normal_req, input wire fast_req);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   wire rd = pready && !pwrite;
   a_rst_quiet: assert property ($fell(sys_rst) |-> !normal_req && !fast_req)
      else $error("request after reset");
   a_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("no ready");
   a_ready_one: assert property (pready |=> !pready) else $error("ready too long");
   a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("stray ready");
   a_err_addr: assert property (pready && (paddr > 32'h28 || paddr[1:0] != 0) |-> pslverr)
      else $error("no slave error");
   a_err_data: assert property (pslverr |-> pready && prdata == 0) else $error("error data");
   a_clr_zero: assert property (rd && (paddr == 32'h8 || paddr == 32'h18) |-> prdata == 0)
      else $error("clear reg readable");
   a_raw_follow: assert property ($stable(src_req)[*8] ##0 rd && paddr == 0 |->
      prdata[31:2] == src_req[31:2]) else $error("raw mismatch");
   a_fast_norm: assert property (fast_req |-> normal_req) else $error("summary lost");
   cover property (rd && pslverr);
   cover property (fast_req);
   cover property (normal_req && !fast_req);
endmodule
bind dlic_top dlic_props i_props(.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .src_req(src_req), .normal_req(normal_req), .fast_req(fast_req));

/* File: dlic_top_test.sv */
/* bench for dlic_top: apb reads noted in a queue, checked by a watcher */
`timescale 1ns/1ps
`include "dlic_map.vh"
module dlic_top_test;
   logic core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [31:0] paddr = 0, pwdata = 0, src_req = 0, seed = 32'hFE71E61E, m, f, n;
   logic pready, pslverr, normal_req, fast_req, evt_irq;
   logic [31:0] prdata;
   logic [1:0] taken;
   logic [32:0] q[$];
   int n_fail = 0, num_checks = 0;
   dlic_top i_dut(.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .src_req(src_req), .normal_req(normal_req), .fast_req(fast_req),
      .evt_irq(evt_irq));
   dlic_core_model i_core(.core_clk(core_clk), .normal_req(normal_req),
      .fast_req(fast_req), .taken(taken));
   initial forever #5 core_clk = ~core_clk;
   task automatic cmp(string s, logic [32:0] e, logic [32:0] g);
      num_checks++;
      if (e !== g) begin
         n_fail++;
         $display("ERROR %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic close_out;
      if (n_fail == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic apb(bit w, logic [5:0] a, logic [31:0] d, logic [32:0] e);
      int k;
      psel <= 1; pwrite <= w; paddr <= {26'h0, a}; pwdata <= d;
      if (!w) q.push_back(e);
      @(posedge core_clk) penable <= 1;
      k = 0;
      do begin @(posedge core_clk); k++; end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin n_fail++; close_out; end
      psel <= 0; penable <= 0;
      @(posedge core_clk);
   endtask
   always @(posedge core_clk) if (pready === 1'b1 && !pwrite) begin
      if (q.size() == 0) cmp("queue", 0, 1);
      else cmp("read", q.pop_front(), {pslverr, prdata});
   end
   initial begin
      repeat (4) @(posedge core_clk);
      sys_rst <= 0;
      @(posedge core_clk);
      apb(0, `DLIC_NRM_EN, 0, 0);
      apb(1, `DLIC_NRM_EN, 32'hFFFFFFFF, 0);
      apb(0, `DLIC_NRM_EN, 0, 32'hFFFFFFFC);
      apb(1, `DLIC_FST_EN, 32'h0000F000, 0);
      apb(0, `DLIC_NRM_EN, 0, 32'hFFFF0FFC);
      apb(1, `DLIC_NRM_CLR, 32'h00000F03, 0);
      apb(1, `DLIC_NRM_EN, 0, 0);
      apb(0, `DLIC_NRM_EN, 0, 32'hFFFF00FC);
      apb(1, `DLIC_EVT_MSK, 0, 0);
      src_req <= 32'h00001000;
      repeat (6) @(posedge core_clk);
      cmp("evt_irq", 0, evt_irq);
      apb(1, `DLIC_EVT_MSK, 3, 0);
      @(posedge core_clk);
      cmp("evt_irq", 1, evt_irq);
      apb(0, `DLIC_EVT_STA, 0, 3);
      @(posedge core_clk);
      cmp("evt_irq", 0, evt_irq);
      repeat (4) begin
         src_req <= $random(seed);
         repeat (9) @(posedge core_clk);
         m = src_req & 32'hFFFFFFFC;
         f = m & 32'h0000F000;
         n = (m & 32'hFFFF00FC) | {31'h0, |f};
         apb(0, `DLIC_NRM_RAW, 0, m | {31'h0, |f});
         apb(0, `DLIC_FST_STA, 0, f | {31'h0, |f});
         apb(0, `DLIC_NRM_STA, 0, n);
         cmp("req", {|f, |n}, taken);
      end
      src_req <= 0;
      apb(1, `DLIC_SWI_CFG, 4, 0);
      repeat (9) @(posedge core_clk);
      apb(0, `DLIC_FST_RAW, 0, 3);
      apb(0, `DLIC_NRM_STA, 0, 1);
      apb(1, `DLIC_SWI_CFG, 2, 0);
      apb(1, `DLIC_NRM_CLR, 2, 0);
      apb(0, `DLIC_NRM_RAW, 0, 2);
      apb(0, `DLIC_NRM_STA, 0, 2);
      apb(0, `DLIC_SWI_CFG, 0, 2);
      apb(1, `DLIC_NRM_EN, 32'h00001000, 0);
      apb(0, `DLIC_FST_EN, 0, 32'h0000E000);
      apb(1, `DLIC_FST_CLR, 32'h00002003, 0);
      apb(0, `DLIC_FST_EN, 0, 32'h0000C000);
      apb(0, `DLIC_FST_CLR, 0, 0);
      apb(0, `DLIC_NRM_CLR, 0, 0);
      apb(0, 6'h2C, 0, 33'h100000000);
      close_out;
   end
endmodule
